// [uhc_cmd_irq_regs.sv]
/*
   Command/status and interrupt register group of the USB host
   controller: list-filled flags, software reset request, ownership
   handshake, overrun counter, event flags, enables and two pointers.
   Assumes register accesses arrive as single-cycle word strobes from
   the PCI memory target, and that all event inputs come from logic
   on clk_sys, so none of them is synchronised here.
*/
`timescale 1ns/1ps

// Operation
// (R01) Two-bit overrun counter counts each schedule overrun, wrapping three to zero.
// (R02) Software setting ownership request sets ownership flag; software alone clears request.
// (R03) Bulk filled set by software or hardware; cleared when bulk head processing starts.
// (R04) Control filled set by software or hardware; cleared when control head starts.
// (R05) Writing one to reset bit starts reset; hardware clears it when done.
// (R06) Ownership flag sets whenever the ownership request bit gets set.
// (R07) Root hub change flag sets when hub or port state changes.
// (R08) Frame overflow flag sets whenever frame counter bit 15 toggles.
// (R09) Unrecoverable error flag reads zero; it and its enables ignore writes.
// (R10) Resume flag sets when resume signalling is seen on a downstream port.
// (R11) Start of frame flag sets on each new-frame signal.
// (R12) Writeback flag sets only after done head reaches the shared area.
// (R13) Scheduling overrun flag sets when the list processor reports overrun.
// (R14) Writing master enable one lets individually enabled sources interrupt.
// (R15) Writing one to an enable bit enables that source; zero changes nothing.
// (R16) Writing master bit of disable register blocks all interrupts.
// (R17) Writing one to a disable bit disables that source; zero changes nothing.
// (R18) Communication area base keeps bits 31:8; low byte reads zero.
// (R19) Periodic current descriptor keeps bits 31:4; low nibble reads zero.
// (R20) Routing bit zero sends interrupt to normal line, one to management.
// (R21) Interrupt asserts while an enabled flag is set and master is on.
// (R22) Writing one to an event flag clears it; zero leaves it.
module uhc_cmd_irq_regs (
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register access port
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   output logic [31:0] regRdData,
   output logic regRdValid,
   // Events from list processor, frame management and root hub
   input wire logic resetDone,
   input wire logic bulkFillSet,
   input wire logic bulkHeadStart,
   input wire logic ctrlFillSet,
   input wire logic ctrlHeadStart,
   input wire logic scheduleOverrunEvt,
   input wire logic doneHeadWritten,
   input wire logic startOfFrameEvt,
   input wire logic resumeDetectEvt,
   input wire logic rootHubChangeEvt,
   input wire logic [15:0] frameCounter,
   input wire logic periodicLoad,
   input wire logic [27:0] periodicValue,
   input wire logic interruptRouting,
   // Command and pointer outputs
   output logic softResetReq,
   output logic bulkListFilled,
   output logic ctrlListFilled,
   output logic ownership_change_request_a,
   output logic [23:0] commAreaBase,
   output logic [27:0] periodicCurrentDescriptor,
   // Interrupt lines
   output logic irqNormal,
   output logic irqSystemMgmt
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic hcReset_q;
   logic bulkFilled_q;
   logic ctrlFilled_q;
   logic ownReq_q;
   logic [1:0] overrunCnt_q;
   logic [31:0] flags_q;
   logic [31:0] enables_q;
   logic [23:0] commBase_q;
   logic [27:0] periodic_q;
   logic frameMsb_q;
   logic irqNormal_q;
   logic irqSmi_q;
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic rdValid_q;
   logic wrCmd;
   logic wrFlags;
   logic wrEnSet;
   logic wrEnClr;
   logic wrBase;
   logic wrPeriodic;
   logic [31:0] setVec;
   logic [31:0] clrVec;
   logic irqPending;
   logic [31:0] activeVec;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // One strobe per register on a write cycle
   assign wrCmd = regWrEn && (regAddr == uhc_pkg::OFF_COMMAND_STATUS);
   assign wrFlags = regWrEn && (regAddr == uhc_pkg::OFF_EVENT_FLAGS);
   assign wrEnSet = regWrEn && (regAddr == uhc_pkg::OFF_ENABLE_SET);
   assign wrEnClr = regWrEn && (regAddr == uhc_pkg::OFF_ENABLE_CLEAR);
   assign wrBase = regWrEn && (regAddr == uhc_pkg::OFF_COMM_AREA_BASE);
   assign wrPeriodic = regWrEn && (regAddr == uhc_pkg::OFF_PERIODIC_CURRENT);

   // ---------------------------------------------------------------
   // Command and status bits
   // ---------------------------------------------------------------
   // Software reset request; a new write wins over the done strobe
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hcReset_q <= 1'b0;
      end else if (wrCmd && regWrData[uhc_pkg::CS_RESET_BIT]) begin
         hcReset_q <= 1'b1; // R05
      end else if (resetDone) begin
         hcReset_q <= 1'b0; // R05
      end
   end

   // Bulk list filled; any set beats the head-start clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bulkFilled_q <= 1'b0;
      end else if ((wrCmd && regWrData[uhc_pkg::CS_BULK_FILLED_BIT]) || bulkFillSet) begin
         bulkFilled_q <= 1'b1; // R03
      end else if (bulkHeadStart) begin
         bulkFilled_q <= 1'b0; // R03
      end
   end

   // Control list filled; any set beats the head-start clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrlFilled_q <= 1'b0;
      end else if ((wrCmd && regWrData[uhc_pkg::CS_CTRL_FILLED_BIT]) || ctrlFillSet) begin
         ctrlFilled_q <= 1'b1; // R04
      end else if (ctrlHeadStart) begin
         ctrlFilled_q <= 1'b0; // R04
      end
   end

   // Ownership request is plain read/write; only software changes it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ownReq_q <= 1'b0;
      end else if (wrCmd) begin
         ownReq_q <= regWrData[uhc_pkg::CS_OWN_REQ_BIT]; // R02
      end
   end

   // Overrun counter follows every overrun report, wraps naturally
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         overrunCnt_q <= uhc_pkg::OVR_CNT_RESET;
      end else if (scheduleOverrunEvt) begin
         overrunCnt_q <= overrunCnt_q + 2'h1; // R01
      end
   end

   // ---------------------------------------------------------------
   // Event flags
   // ---------------------------------------------------------------
   // Frame counter top bit history for overflow detection
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         frameMsb_q <= 1'b0;
      end else begin
         frameMsb_q <= frameCounter[uhc_pkg::FRAME_MSB];
      end
   end

   // Gather set causes; bit 4 never sets
   always_comb begin
      setVec = '0;
      setVec[uhc_pkg::EV_SCHED_OVERRUN] = scheduleOverrunEvt; // R13
      setVec[uhc_pkg::EV_DONE_WRITEBACK] = doneHeadWritten; // R12
      setVec[uhc_pkg::EV_START_OF_FRAME] = startOfFrameEvt; // R11
      setVec[uhc_pkg::EV_RESUME] = resumeDetectEvt; // R10
      setVec[uhc_pkg::EV_FRAME_OVERFLOW] = frameCounter[uhc_pkg::FRAME_MSB] ^ frameMsb_q; // R08
      setVec[uhc_pkg::EV_ROOT_HUB_CHANGE] = rootHubChangeEvt; // R07
      setVec[uhc_pkg::EV_OWNERSHIP] = wrCmd && regWrData[uhc_pkg::CS_OWN_REQ_BIT]; // R06 R02
      setVec = setVec & uhc_pkg::EVENT_MASK;
   end

   // Write-one-to-clear, limited to implemented bits
   assign clrVec = wrFlags ? (regWrData & uhc_pkg::EVENT_MASK) : '0; // R22 R09

   // Sticky flag per bit; a same-cycle set overrides the clear
   for (genvar i = 0; i < 32; i++) begin : g_flag
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            flags_q[i] <= uhc_pkg::FLAGS_RESET[i];
         end else if (setVec[i]) begin
            flags_q[i] <= 1'b1;
         end else if (clrVec[i]) begin
            flags_q[i] <= 1'b0; // R22
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt enables
   // ---------------------------------------------------------------
   // Set and clear registers share one enable image per bit; clear wins
   for (genvar i = 0; i < 32; i++) begin : g_enable
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            enables_q[i] <= uhc_pkg::ENABLE_RESET[i];
         end else if (wrEnClr && regWrData[i] && uhc_pkg::ENABLE_MASK[i]) begin
            enables_q[i] <= 1'b0; // R16 R17 R09
         end else if (wrEnSet && regWrData[i] && uhc_pkg::ENABLE_MASK[i]) begin
            enables_q[i] <= 1'b1; // R14 R15 R09
         end
      end
   end

   // ---------------------------------------------------------------
   // Pointers
   // ---------------------------------------------------------------
   // Communication area base, 256-byte aligned
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         commBase_q <= uhc_pkg::COMM_BASE_RESET;
      end else if (wrBase) begin
         commBase_q <= regWrData[31:8]; // R18
      end
   end

   // Periodic descriptor; list processor load overrides software
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         periodic_q <= uhc_pkg::PERIODIC_RESET;
      end else if (periodicLoad) begin
         periodic_q <= periodicValue; // R19
      end else if (wrPeriodic) begin
         periodic_q <= regWrData[31:4]; // R19
      end
   end

   // ---------------------------------------------------------------
   // Interrupt generation
   // ---------------------------------------------------------------
   // Flags whose own enable is on
   assign activeVec = flags_q & enables_q & uhc_pkg::EVENT_MASK; // R15 R17

   // Any enabled flag with master on raises the request
   assign irqPending = enables_q[uhc_pkg::EN_MASTER_BIT] && (|activeVec); // R14 R16 R21

   // Normal interrupt line while routing bit is low
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irqNormal_q <= 1'b0;
      end else begin
         irqNormal_q <= irqPending && !interruptRouting; // R20
      end
   end

   // Management interrupt line while routing bit is high
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irqSmi_q <= 1'b0;
      end else begin
         irqSmi_q <= irqPending && interruptRouting; // R20
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Read mux; reserved bits and unmapped offsets read zero
   always_comb begin
      rdData_d = '0;
      case (regAddr)
         uhc_pkg::OFF_COMMAND_STATUS: begin
            rdData_d[uhc_pkg::CS_OVR_CNT_MSB:uhc_pkg::CS_OVR_CNT_LSB] = overrunCnt_q;
            rdData_d[uhc_pkg::CS_OWN_REQ_BIT] = ownReq_q;
            rdData_d[uhc_pkg::CS_BULK_FILLED_BIT] = bulkFilled_q;
            rdData_d[uhc_pkg::CS_CTRL_FILLED_BIT] = ctrlFilled_q;
            rdData_d[uhc_pkg::CS_RESET_BIT] = hcReset_q;
         end
         uhc_pkg::OFF_EVENT_FLAGS: begin
            rdData_d = flags_q; // R09
         end
         uhc_pkg::OFF_ENABLE_SET: begin
            rdData_d = enables_q;
         end
         uhc_pkg::OFF_ENABLE_CLEAR: begin
            rdData_d = enables_q;
         end
         uhc_pkg::OFF_COMM_AREA_BASE: begin
            rdData_d = {commBase_q, 8'h00}; // R18
         end
         uhc_pkg::OFF_PERIODIC_CURRENT: begin
            rdData_d = {periodic_q, 4'h0}; // R19
         end
         default: begin
            rdData_d = '0;
         end
      endcase
   end

   // Read data is captured on the strobe edge and held until the next read
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdData_q <= '0;
      end else if (regRdEn) begin
         rdData_q <= rdData_d;
      end
   end

   // Read valid answers every strobe one cycle later
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= regRdEn;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign softResetReq = hcReset_q;
   assign bulkListFilled = bulkFilled_q;
   assign ctrlListFilled = ctrlFilled_q;
   assign ownership_change_request_a = ownReq_q;
   assign commAreaBase = commBase_q;
   assign periodicCurrentDescriptor = periodic_q;
   assign irqNormal = irqNormal_q;
   assign irqSystemMgmt = irqSmi_q;

endmodule

// [uhc_cmd_irq_regs_checker.sv]
/*
   Port-level assertions for the command, status and interrupt register group.
   Assumes single-cycle register strobes on clk_sys and an active-low reset.
*/
`timescale 1ns/1ps
module uhc_cmd_irq_regs_checker (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic [31:0] regRdData,
   input wire logic regRdValid,
   input wire logic resetDone,
   input wire logic bulkFillSet,
   input wire logic bulkHeadStart,
   input wire logic interruptRouting,
   input wire logic softResetReq,
   input wire logic bulkListFilled,
   input wire logic ownership_change_request_a,
   input wire logic [23:0] commAreaBase,
   input wire logic irqNormal,
   input wire logic irqSystemMgmt
);
   // Decoded write strobes
   wire wrCmd = regWrEn && regAddr == 8'h08;
   wire wrEnSet = regWrEn && regAddr == 8'h10;
   wire wrEnClr = regWrEn && regAddr == 8'h14;
   wire wrBase = regWrEn && regAddr == 8'h18;
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   read_valid_a: assert property (regRdEn |=> regRdValid)
      else $error("read strobe not answered");
   reset_set_a: assert property (wrCmd && regWrData[0] |=> softResetReq)
      else $error("software reset request not set");
   reset_clear_a: assert property (resetDone && !(wrCmd && regWrData[0]) |=> !softResetReq)
      else $error("software reset request not cleared");
   bulk_set_a: assert property (bulkFillSet |=> bulkListFilled)
      else $error("bulk filled not set");
   bulk_clear_a: assert property (bulkHeadStart && !bulkFillSet && !(wrCmd && regWrData[2]) |=> !bulkListFilled)
      else $error("bulk filled not cleared");
   own_write_a: assert property (wrCmd |=> ownership_change_request_a == $past(regWrData[3]))
      else $error("ownership request does not follow write");
   own_hold_a: assert property (!wrCmd |=> $stable(ownership_change_request_a))
      else $error("ownership request changed without write");
   base_store_a: assert property (wrBase |=> commAreaBase == $past(regWrData[31:8]))
      else $error("base pointer not stored");
   route_normal_a: assert property (irqNormal |-> !$past(interruptRouting) && !irqSystemMgmt)
      else $error("normal interrupt on wrong route");
   route_mgmt_a: assert property (irqSystemMgmt |-> $past(interruptRouting))
      else $error("management interrupt on wrong route");
   master_off_a: assert property (wrEnClr && regWrData[31] ##1 !wrEnSet |=> !(irqNormal || irqSystemMgmt))
      else $error("interrupt after master disable");
   unrec_zero_a: assert property (regRdValid && $past(regAddr) inside {8'h0c, 8'h10, 8'h14} |-> !regRdData[4])
      else $error("unrecoverable bit reads one");
   // Main scenarios reached
   cover property (wrEnClr && regWrData[31]);
   cover property (irqSystemMgmt);
   cover property ($fell(softResetReq));
endmodule

bind uhc_cmd_irq_regs uhc_cmd_irq_regs_checker chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
   .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
   .regRdValid(regRdValid), .resetDone(resetDone), .bulkFillSet(bulkFillSet), .bulkHeadStart(bulkHeadStart),
   .interruptRouting(interruptRouting), .softResetReq(softResetReq), .bulkListFilled(bulkListFilled),
   .ownership_change_request_a(ownership_change_request_a), .commAreaBase(commAreaBase), .irqNormal(irqNormal),
   .irqSystemMgmt(irqSystemMgmt));

// [uhc_pkg.sv]
/*
   Shared constants of the USB host command, status and interrupt
   register group: offsets, field positions, masks and reset values.
   Assumes byte offsets relative to the operational register base.
*/
package uhc_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_COMMAND_STATUS = 8'h08;
   localparam logic [7:0] OFF_EVENT_FLAGS = 8'h0c;
   localparam logic [7:0] OFF_ENABLE_SET = 8'h10;
   localparam logic [7:0] OFF_ENABLE_CLEAR = 8'h14;
   localparam logic [7:0] OFF_COMM_AREA_BASE = 8'h18;
   localparam logic [7:0] OFF_PERIODIC_CURRENT = 8'h1c;

   // ---------------------------------------------------------------
   // Command and status field positions
   // ---------------------------------------------------------------
   localparam int CS_RESET_BIT = 0;
   localparam int CS_CTRL_FILLED_BIT = 1;
   localparam int CS_BULK_FILLED_BIT = 2;
   localparam int CS_OWN_REQ_BIT = 3;
   localparam int CS_OVR_CNT_LSB = 16;
   localparam int CS_OVR_CNT_MSB = 17;

   // ---------------------------------------------------------------
   // Event flag positions
   // ---------------------------------------------------------------
   localparam int EV_SCHED_OVERRUN = 0;
   localparam int EV_DONE_WRITEBACK = 1;
   localparam int EV_START_OF_FRAME = 2;
   localparam int EV_RESUME = 3;
   localparam int EV_UNRECOVERABLE = 4;
   localparam int EV_FRAME_OVERFLOW = 5;
   localparam int EV_ROOT_HUB_CHANGE = 6;
   localparam int EV_OWNERSHIP = 30;
   localparam int EN_MASTER_BIT = 31;
   localparam int FRAME_MSB = 15;

   // ---------------------------------------------------------------
   // Implemented-bit masks and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] EVENT_MASK = 32'h4000_006f;
   localparam logic [31:0] ENABLE_MASK = 32'hc000_006f;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [1:0] OVR_CNT_RESET = 2'h0;
   localparam logic [23:0] COMM_BASE_RESET = 24'h00_0000;
   localparam logic [27:0] PERIODIC_RESET = 28'h000_0000;

endpackage

// [uhc_tb.sv]
/*
   Self-checking testbench of the command, status and interrupt register group.
   Assumes the register port and event pulses of the design, one 25 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
   logic clk_sys, reset_n, regWrEn, regRdEn, regRdValid, interruptRouting;
   logic softResetReq, bulkListFilled, ctrlListFilled, ownership_change_request_a, irqNormal, irqSystemMgmt;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, expFlags;
   logic [15:0] frameCounter;
   logic [27:0] periodicValue, periodicCurrentDescriptor;
   logic [23:0] commAreaBase;
   logic [10:0] ev;
   int n_mismatch = 0;
   int n_tests = 0;
   uhc_cmd_irq_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .resetDone(ev[4]), .bulkFillSet(ev[5]), .bulkHeadStart(ev[7]), .ctrlFillSet(ev[8]),
      .ctrlHeadStart(ev[9]), .scheduleOverrunEvt(ev[0]), .doneHeadWritten(ev[1]), .startOfFrameEvt(ev[2]),
      .resumeDetectEvt(ev[3]), .rootHubChangeEvt(ev[6]), .frameCounter(frameCounter), .periodicLoad(ev[10]),
      .periodicValue(periodicValue), .interruptRouting(interruptRouting), .softResetReq(softResetReq),
      .bulkListFilled(bulkListFilled), .ctrlListFilled(ctrlListFilled),
      .ownership_change_request_a(ownership_change_request_a), .commAreaBase(commAreaBase),
      .periodicCurrentDescriptor(periodicCurrentDescriptor), .irqNormal(irqNormal),
      .irqSystemMgmt(irqSystemMgmt));
   // 25 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Bus-cycle helpers: advance, compare, write, read, pulse an event
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      tick(1);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      tick(1);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      tick(1);
      regRdEn = 1'b1;
      regAddr = a;
      tick(1);
      regRdEn = 1'b0;
      chk({31'h0, regRdValid}, 32'h1);
      chk(regRdData, e);
   endtask
   task automatic pulse(input int i);
      tick(1);
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
   endtask
   // Verdict and end of run
   task automatic complete_run;
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      complete_run;
   end
   // Main sequence
   initial begin
      {regWrEn, regRdEn, interruptRouting, reset_n} = 4'h0;
      {regAddr, regWrData, frameCounter, periodicValue, ev} = '0;
      tick(10);
      reset_n = 1'b1;
      for (int a = 4; a <= 28; a += 4) rd(8'(a), 32'h0);
      wr(8'h08, 32'h1);
      wr(8'h08, 32'h0);
      chk({31'h0, softResetReq}, 32'h1);
      pulse(4);
      chk({31'h0, softResetReq}, 32'h0);
      wr(8'h08, 32'h6);
      rd(8'h08, 32'h6);
      chk({28'h0, ownership_change_request_a, bulkListFilled, ctrlListFilled, softResetReq}, 32'h6);
      pulse(7);
      rd(8'h08, 32'h2);
      pulse(9);
      rd(8'h08, 32'h0);
      pulse(5);
      pulse(8);
      rd(8'h08, 32'h6);
      pulse(7);
      pulse(9);
      wr(8'h08, 32'h8);
      rd(8'h0c, 32'h4000_0000);
      wr(8'h0c, 32'h0);
      rd(8'h0c, 32'h4000_0000);
      wr(8'h0c, 32'h4000_0000);
      rd(8'h0c, 32'h0);
      rd(8'h08, 32'h8);
      chk({28'h0, ownership_change_request_a, bulkListFilled, ctrlListFilled, softResetReq}, 32'h8);
      wr(8'h08, 32'h0);
      for (int k = 1; k <= 4; k++) begin
         pulse(0);
         rd(8'h08, 32'(k % 4) << 16);
      end
      wr(8'h0c, 32'hffff_ffff);
      expFlags = 32'h0;
      for (int j = 0; j < 7; j++) if (j != 4 && j != 5) begin
         pulse(j);
         expFlags[j] = 1'b1;
         rd(8'h0c, expFlags);
      end
      frameCounter = 16'h8000;
      expFlags[5] = 1'b1;
      rd(8'h0c, expFlags);
      wr(8'h0c, 32'h30);
      rd(8'h0c, expFlags & 32'hffff_ffdf);
      frameCounter = 16'h7fff;
      rd(8'h0c, expFlags);
      wr(8'h0c, 32'hffff_ffff);
      rd(8'h0c, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, 32'hc000_006f);
      wr(8'h14, 32'h4);
      wr(8'h10, 32'h0);
      rd(8'h14, 32'hc000_006b);
      pulse(2);
      tick(2);
      chk({30'h0, irqSystemMgmt, irqNormal}, 32'h0);
      pulse(6);
      tick(2);
      chk({30'h0, irqSystemMgmt, irqNormal}, 32'h1);
      interruptRouting = 1'b1;
      tick(2);
      chk({30'h0, irqSystemMgmt, irqNormal}, 32'h2);
      interruptRouting = 1'b0;
      wr(8'h14, 32'h8000_0000);
      tick(2);
      chk({30'h0, irqSystemMgmt, irqNormal}, 32'h0);
      wr(8'h10, 32'h8000_0000);
      tick(2);
      chk({30'h0, irqSystemMgmt, irqNormal}, 32'h1);
      wr(8'h0c, 32'hffff_ffff);
      tick(2);
      chk({30'h0, irqSystemMgmt, irqNormal}, 32'h0);
      wr(8'h18, 32'hffff_ffff);
      rd(8'h18, 32'hffff_ff00);
      chk({8'h0, commAreaBase}, 32'h00ff_ffff);
      wr(8'h1c, 32'hffff_ffff);
      rd(8'h1c, 32'hffff_fff0);
      periodicValue = 28'h123_4567;
      pulse(10);
      rd(8'h1c, 32'h1234_5670);
      chk({4'h0, periodicCurrentDescriptor}, 32'h0123_4567);
      complete_run;
   end
endmodule
